/* File: verilog/npd_detector.sv */
// Compressed-stream burst detector with register port and event output.
// Assumes words, valid and frame tick come from receiver logic on clk_sys.
`timescale 1ns/1ps
`include "npd_cfg.svh"

module npd_detector (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic powerDownInN,
  // Decoded receive stream
  input wire npd_pkg::npd_word_t wordData,
  input wire logic wordValid,
  input wire logic frameTick,
  // Register port
  input wire logic [2:0] regAddr,
  input wire logic [15:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [15:0] regRdData_r,
  // Status and events
  output logic nonPcmDetect_r,
  output logic cdStreamDetectFlag_r,
  output logic eventOut_r,
  output logic irq_r
);
  import npd_pkg::*;

  // =====================================================
  // Power-down pin synchroniser
  logic pdnMeta_r;
  logic pdnSync_r;
  logic blockRst;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      pdnMeta_r <= 1'b0;
      pdnSync_r <= 1'b0;
    end else begin
      pdnMeta_r <= powerDownInN;
      pdnSync_r <= pdnMeta_r;
    end
  end

  // Power-down clears the block the same as a system reset
  assign blockRst = reset | ~pdnSync_r;

  // =====================================================
  // Word history, newest in entry 0
  npd_word_t hist_r [0:4];

  always_ff @(posedge clk_sys) begin
    if (blockRst) begin
      hist_r[0] <= `NPD_SYNC_ZERO;
    end else if (wordValid) begin
      hist_r[0] <= wordData;
    end
  end

  genvar gi;
  generate
    for (gi = 1; gi < 5; gi++) begin : g_hist
      always_ff @(posedge clk_sys) begin
        if (blockRst) begin
          hist_r[gi] <= `NPD_SYNC_ZERO;
        end else if (wordValid) begin
          hist_r[gi] <= hist_r[gi - 1];
        end
      end
    end
  endgenerate

  // =====================================================
  // Sync matching
  // Reset fills history with zeros, so a first word pair alone could
  // fake a sync; the fill counter blocks that until five words arrived.
  logic [2:0] fill_r;
  logic histFull;
  logic syncOneOk;
  logic syncHit;
  logic cdHit;

  always_ff @(posedge clk_sys) begin
    if (blockRst) begin
      fill_r <= 3'h0;
    end else if (wordValid && fill_r != 3'h5) begin
      fill_r <= fill_r + 3'h1;
    end
  end

  assign histFull = (fill_r == 3'h5);
  assign syncOneOk = (hist_r[0] == `NPD_SYNC_ONE) ||
                     (hist_r[0] == `NPD_SYNC_ONE_ALT);
  assign syncHit = wordValid && histFull && syncOneOk &&
                   hist_r[1] == `NPD_SYNC_ZERO &&
                   hist_r[2] == `NPD_SYNC_ZERO &&
                   hist_r[3] == `NPD_SYNC_ZERO &&
                   hist_r[4] == `NPD_SYNC_ZERO &&
                   wordData == `NPD_SYNC_TWO;
  assign cdHit = wordValid && fill_r != 3'h0 &&
                 hist_r[0] == `NPD_CD_SYNC_HI &&
                 wordData == `NPD_CD_SYNC_LO;

  // =====================================================
  // Detect flags with frame timeouts
  logic [1:0] restartVec;
  logic [1:0] activeVec;

  assign restartVec = {cdHit, syncHit};

  generate
    for (gi = 0; gi < 2; gi++) begin : g_flag
      npd_frame_timer u_timer (
        .clk_sys(clk_sys),
        .reset(blockRst),
        .restart(restartVec[gi]),
        .frameTick(frameTick),
        .active_r(activeVec[gi])
      );
    end
  endgenerate

  // Registered copies keep the top outputs on flip-flops
  always_ff @(posedge clk_sys) begin
    if (blockRst) begin
      nonPcmDetect_r <= 1'b0;
      cdStreamDetectFlag_r <= 1'b0;
    end else begin
      nonPcmDetect_r <= activeVec[0];
      cdStreamDetectFlag_r <= activeVec[1];
    end
  end

  // =====================================================
  // Preamble capture
  npd_state_t state_r;
  npd_word_t burstInfo_r;
  npd_word_t burstLength_r;
  logic captureDone;

  always_ff @(posedge clk_sys) begin
    if (blockRst) begin
      state_r <= ST_HUNT;
    end else begin
      case (state_r)
        ST_HUNT: begin
          if (syncHit) begin
            state_r <= ST_INFO;
          end
        end
        ST_INFO: begin
          if (wordValid) begin
            state_r <= ST_LEN;
          end
        end
        ST_LEN: begin
          if (wordValid) begin
            state_r <= ST_HUNT;
          end
        end
        default: begin
          state_r <= ST_HUNT;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (blockRst) begin
      burstInfo_r <= 16'h0000;
    end else if (state_r == ST_INFO && wordValid) begin
      burstInfo_r <= wordData;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (blockRst) begin
      burstLength_r <= 16'h0000;
    end else if (state_r == ST_LEN && wordValid) begin
      burstLength_r <= wordData;
    end
  end

  assign captureDone = (state_r == ST_LEN) && wordValid;

  // =====================================================
  // Burst info decode
  logic [4:0] dataType;
  logic typeNull;
  logic typePause;
  logic typeReserved;
  logic typeCompressed;
  logic zeroFieldBad;
  logic [15:0] decodeWord;

  assign dataType = burstInfo_r[4:0];
  assign typeNull = (dataType == `NPD_TYPE_NULL);
  assign typePause = (dataType == `NPD_TYPE_PAUSE);
  assign typeReserved = (dataType == `NPD_TYPE_RSV_A) ||
                        (dataType == `NPD_TYPE_RSV_B) ||
                        (dataType >= `NPD_TYPE_RSV_HI);
  assign typeCompressed = ~(typeNull | typePause | typeReserved);
  // Source breach is flagged only; capture still takes the word
  assign zeroFieldBad = (|burstInfo_r[6:5]) | (|burstInfo_r[15:13]);
  assign decodeWord = {5'h00, typeCompressed, zeroFieldBad,
                       burstInfo_r[`NPD_PC_ERR_BIT],
                       typeReserved, typePause, typeNull, dataType};

  // =====================================================
  // Control register
  logic [1:0] holdSel_r;
  logic maskNpcm_r;
  logic maskCd_r;
  logic ctrlWrite;

  assign ctrlWrite = regWrite && regAddr == `NPD_ADDR_CTRL;

  always_ff @(posedge clk_sys) begin
    if (blockRst) begin
      holdSel_r <= `NPD_HOLD_SEL_RST;
      maskNpcm_r <= 1'b0;
      maskCd_r <= 1'b0;
    end else if (ctrlWrite) begin
      holdSel_r <= regWrData[1:0];
      maskNpcm_r <= regWrData[`NPD_CTRL_MASK_NPCM];
      maskCd_r <= regWrData[`NPD_CTRL_MASK_CD];
    end
  end

  // =====================================================
  // Event output with hold time in frames
  logic eventSrc;
  logic [12:0] holdLen;
  logic [12:0] holdCnt_r;

  assign eventSrc = (nonPcmDetect_r & ~maskNpcm_r) |
                    (cdStreamDetectFlag_r & ~maskCd_r);

  always_comb begin
    case (holdSel_r)
      2'h0: holdLen = `NPD_HOLD_SEL0;
      2'h1: holdLen = `NPD_HOLD_SEL1;
      2'h2: holdLen = `NPD_HOLD_SEL2;
      default: holdLen = `NPD_HOLD_SEL3;
    endcase
  end

  // Hold reloads while any unmasked detect flag stands, counts down in frames after
  always_ff @(posedge clk_sys) begin
    if (blockRst) begin
      holdCnt_r <= 13'h0000;
    end else if (eventSrc) begin
      holdCnt_r <= holdLen;
    end else if (frameTick && holdCnt_r != 13'h0000) begin
      holdCnt_r <= holdCnt_r - 13'h0001;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (blockRst) begin
      eventOut_r <= 1'b0;
    end else begin
      eventOut_r <= eventSrc || holdCnt_r != 13'h0000;
    end
  end

  // =====================================================
  // Interrupt status, clear and enable
  logic [`NPD_EV_COUNT-1:0] evPulse;
  logic [`NPD_EV_COUNT-1:0] irqStat_r;
  logic [`NPD_EV_COUNT-1:0] irqEn_r;
  logic [`NPD_EV_COUNT-1:0] irqClr;
  logic prevNpcm_r;
  logic prevCd_r;

  always_ff @(posedge clk_sys) begin
    if (blockRst) begin
      prevNpcm_r <= 1'b0;
      prevCd_r <= 1'b0;
    end else begin
      prevNpcm_r <= nonPcmDetect_r;
      prevCd_r <= cdStreamDetectFlag_r;
    end
  end

  always_comb begin
    evPulse = '0;
    evPulse[`NPD_EV_NPCM_FOUND] = nonPcmDetect_r & ~prevNpcm_r;
    evPulse[`NPD_EV_NPCM_LOST] = ~nonPcmDetect_r & prevNpcm_r;
    evPulse[`NPD_EV_CD_FOUND] = cdStreamDetectFlag_r & ~prevCd_r;
    evPulse[`NPD_EV_CD_LOST] = ~cdStreamDetectFlag_r & prevCd_r;
    evPulse[`NPD_EV_CAPTURE] = captureDone;
  end

  assign irqClr = (regWrite && regAddr == `NPD_ADDR_IRQ_CLR) ?
                  regWrData[`NPD_EV_COUNT-1:0] : '0;

  // A new event in the clearing cycle survives the clear
  always_ff @(posedge clk_sys) begin
    if (blockRst) begin
      irqStat_r <= '0;
    end else begin
      irqStat_r <= (irqStat_r & ~irqClr) | evPulse;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (blockRst) begin
      irqEn_r <= '0;
    end else if (regWrite && regAddr == `NPD_ADDR_IRQ_EN) begin
      irqEn_r <= regWrData[`NPD_EV_COUNT-1:0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (blockRst) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(((irqStat_r & ~irqClr) | evPulse) & irqEn_r);
    end
  end

  // =====================================================
  // Read port, data in the cycle after the strobe
  always_ff @(posedge clk_sys) begin
    if (blockRst) begin
      regRdData_r <= 16'h0000;
    end else if (regRead) begin
      case (regAddr)
        `NPD_ADDR_CTRL: regRdData_r <= {12'h000, maskCd_r, maskNpcm_r,
                                        holdSel_r};
        `NPD_ADDR_FLAGS: regRdData_r <= {13'h0000, eventOut_r,
                                         cdStreamDetectFlag_r,
                                         nonPcmDetect_r};
        `NPD_ADDR_INFO: regRdData_r <= burstInfo_r;
        `NPD_ADDR_LENGTH: regRdData_r <= burstLength_r;
        `NPD_ADDR_DECODE: regRdData_r <= decodeWord;
        `NPD_ADDR_IRQ_STAT: regRdData_r <= {11'h000, irqStat_r};
        `NPD_ADDR_IRQ_EN: regRdData_r <= {11'h000, irqEn_r};
        default: regRdData_r <= 16'h0000;
      endcase
    end else begin
      regRdData_r <= 16'h0000;
    end
  end

  // =====================================================
  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (blockRst);

  sequence s_syncSeen;
    syncHit && state_r == ST_HUNT;
  endsequence

  sequence s_infoWord;
    state_r == ST_INFO && wordValid;
  endsequence

  property p_syncSetsFlag;
    syncHit |=> ##1 nonPcmDetect_r;
  endproperty
  a_syncSetsFlag: assert property (p_syncSetsFlag)
    else $error("Sync pattern did not set non-PCM flag");

  property p_captureInfo;
    s_syncSeen ##1 s_infoWord |=> burstInfo_r == $past(wordData);
  endproperty
  a_captureInfo: assert property (p_captureInfo)
    else $error("Burst info word not captured after sync");

  property p_captureLength;
    captureDone |=> burstLength_r == $past(wordData) && state_r == ST_HUNT;
  endproperty
  a_captureLength: assert property (p_captureLength)
    else $error("Length word not captured");

  property p_cdSetsFlag;
    cdHit |=> ##1 cdStreamDetectFlag_r;
  endproperty
  a_cdSetsFlag: assert property (p_cdSetsFlag)
    else $error("CD sync did not set its flag");

  property p_typeRead;
    regRead && regAddr == `NPD_ADDR_DECODE |=>
      regRdData_r[4:0] == $past(burstInfo_r[4:0]) &&
      regRdData_r[5] == ($past(burstInfo_r[4:0]) == `NPD_TYPE_NULL);
  endproperty
  a_typeRead: assert property (p_typeRead)
    else $error("Data type decode read wrong");

  property p_errorFlagRead;
    regRead && regAddr == `NPD_ADDR_DECODE |=>
      regRdData_r[8] == $past(burstInfo_r[`NPD_PC_ERR_BIT]);
  endproperty
  a_errorFlagRead: assert property (p_errorFlagRead)
    else $error("Error flag read wrong");

  property p_zeroUntilCapture;
    disable iff (reset)
    $rose(pdnSync_r) |-> burstInfo_r == 16'h0000 &&
      burstLength_r == 16'h0000;
  endproperty
  a_zeroUntilCapture: assert property (p_zeroUntilCapture)
    else $error("Captured words not zero after power-down");

  property p_eventFollows;
    eventSrc |=> eventOut_r ##1 eventOut_r;
  endproperty
  a_eventFollows: assert property (p_eventFollows)
    else $error("Event output missed an unmasked flag");

  property p_eventHold;
    $fell(eventOut_r) |-> !$past(eventSrc) && $past(holdCnt_r) == 13'h0000;
  endproperty
  a_eventHold: assert property (p_eventHold)
    else $error("Event output dropped before hold expired");

endmodule : npd_detector

/* File: verilog/npd_cfg.svh */
// Constants for the compressed-stream burst detector.
// Assumes inclusion by bare name from every design file that needs them.
`ifndef NPD_CFG_SVH
`define NPD_CFG_SVH

// =====================================================
// Sync patterns
`define NPD_SYNC_ZERO 16'h0000
`define NPD_SYNC_ONE 16'h7872
`define NPD_SYNC_ONE_ALT 16'hf872
`define NPD_SYNC_TWO 16'h4e1f
`define NPD_CD_SYNC_HI 16'h1fff
`define NPD_CD_SYNC_LO 16'he800

// =====================================================
// Frame counts
`define NPD_FRAME_TIMEOUT 13'h1000
`define NPD_HOLD_SEL0 13'h0200
`define NPD_HOLD_SEL1 13'h0400
`define NPD_HOLD_SEL2 13'h0800
`define NPD_HOLD_SEL3 13'h1000
`define NPD_HOLD_SEL_RST 2'h1

// =====================================================
// Register map
`define NPD_ADDR_CTRL 3'h0
`define NPD_ADDR_FLAGS 3'h1
`define NPD_ADDR_INFO 3'h2
`define NPD_ADDR_LENGTH 3'h3
`define NPD_ADDR_DECODE 3'h4
`define NPD_ADDR_IRQ_STAT 3'h5
`define NPD_ADDR_IRQ_CLR 3'h6
`define NPD_ADDR_IRQ_EN 3'h7

// =====================================================
// Burst info fields and type codes
`define NPD_TYPE_NULL 5'h00
`define NPD_TYPE_RSV_A 5'h02
`define NPD_TYPE_PAUSE 5'h03
`define NPD_TYPE_RSV_B 5'h0a
`define NPD_TYPE_RSV_HI 5'h10
`define NPD_PC_ERR_BIT 7

// Control field positions
`define NPD_CTRL_MASK_NPCM 2
`define NPD_CTRL_MASK_CD 3

// Interrupt event bits
`define NPD_EV_NPCM_FOUND 0
`define NPD_EV_NPCM_LOST 1
`define NPD_EV_CD_FOUND 2
`define NPD_EV_CD_LOST 3
`define NPD_EV_CAPTURE 4
`define NPD_EV_COUNT 5

`endif

/* File: verilog/npd_pkg.sv */
// Types shared by the burst detector design files.
// Assumes npd_cfg.svh holds the numeric constants.
package npd_pkg;

  // =====================================================
  // Preamble capture states
  typedef enum logic [2:0] {
    ST_HUNT = 3'b001,
    ST_INFO = 3'b010,
    ST_LEN = 3'b100
  } npd_state_t;

  typedef logic [15:0] npd_word_t;

endpackage : npd_pkg

/* File: verilog/npd_frame_timer.sv */
// Retriggerable frame timeout for one detect flag.
// Assumes frameTick is a one-cycle pulse per received frame.
`timescale 1ns/1ps
`include "npd_cfg.svh"

module npd_frame_timer (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Control
  input wire logic restart,
  input wire logic frameTick,
  // Flag
  output logic active_r
);
  import npd_pkg::*;

  logic [12:0] count_r;

  // =====================================================
  // Frame count since last sync; restart wins over expiry
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      count_r <= 13'h0000;
    end else if (restart) begin
      count_r <= 13'h0000;
    end else if (active_r && frameTick) begin
      count_r <= count_r + 13'h0001;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      active_r <= 1'b0;
    end else if (restart) begin
      active_r <= 1'b1;
    end else if (frameTick && count_r == `NPD_FRAME_TIMEOUT - 13'h0001) begin
      active_r <= 1'b0;
    end
  end

  // =====================================================
  // Checks
  property p_expiryCount;
    @(posedge clk_sys) disable iff (reset)
    $fell(active_r) |-> $past(count_r) == `NPD_FRAME_TIMEOUT - 13'h0001;
  endproperty
  a_expiryCount: assert property (p_expiryCount)
    else $error("Flag dropped before full frame timeout");

  property p_restartHolds;
    @(posedge clk_sys) disable iff (reset)
    restart |=> active_r && count_r == 13'h0000;
  endproperty
  a_restartHolds: assert property (p_restartHolds)
    else $error("Sync did not rearm the flag");

endmodule : npd_frame_timer

/* File: sim/npd_rx_model.sv */
// Receiver front-end model: hands decoded words and frame ticks on.
// Assumes words are taken on each rising clk_sys edge with valid high.
`timescale 1ns/1ps
`include "npd_cfg.svh"

module npd_rx_model (
  // Clock
  input wire logic clk_sys,
  // Frame rate control
  input wire logic tickEn,
  // Decoded stream
  output npd_pkg::npd_word_t wordData,
  output logic wordValid,
  output logic frameTick
);
  import npd_pkg::*;

  initial begin
    wordData = 16'hffff;
    wordValid = 1'b0;
    frameTick = 1'b0;
  end

  // =====================================================
  // Frame ticks, one per cycle to keep long counts short
  // Plain always: frameTick also has a start value above
  always @(posedge clk_sys) begin
    frameTick <= tickEn;
  end

  // =====================================================
  // Word transport
  task sendWord(input npd_word_t w);
    wordData <= w;
    wordValid <= 1'b1;
    @(posedge clk_sys);
  endtask : sendWord

  // Released data toggles so a stale word is never mistaken
  task idleBus();
    wordValid <= 1'b0;
    wordData <= ~wordData;
  endtask : idleBus

  task sendBurst(input int nZero, input npd_word_t syncOne,
                 input npd_word_t info, input npd_word_t len,
                 input logic allowBad);
    npd_word_t pc;
    int i;
    pc = allowBad ? info : (info & 16'h1f9f);
    @(posedge clk_sys);
    for (i = 0; i < nZero; i++) begin
      sendWord(`NPD_SYNC_ZERO);
    end
    sendWord(syncOne);
    sendWord(`NPD_SYNC_TWO);
    sendWord(pc);
    sendWord(len);
    idleBus();
  endtask : sendBurst

  task sendCdSync();
    @(posedge clk_sys);
    sendWord(`NPD_CD_SYNC_HI);
    sendWord(`NPD_CD_SYNC_LO);
    idleBus();
  endtask : sendCdSync

endmodule : npd_rx_model

/* File: sim/tb_nonpcm_burst_detector.sv */
// Self-checking bench for the burst detector.
// Assumes one frame tick per clock cycle from the receiver model.
`timescale 1ns/1ps
`include "npd_cfg.svh"

module tb_nonpcm_burst_detector;
  import npd_pkg::*;

  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic powerDownInN = 1'b1;
  logic tickEn = 1'b0;
  npd_word_t wordData;
  logic wordValid;
  logic frameTick;
  logic [2:0] regAddr = 3'h0;
  logic [15:0] regWrData = 16'h0000;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic [15:0] regRdData_r;
  logic nonPcmDetect_r;
  logic cdStreamDetectFlag_r;
  logic eventOut_r;
  logic irq_r;
  int nFail = 0;
  int samplesChecked = 0;
  int cycles = 0;
  int i;
  npd_word_t tbl [8] = '{16'h0000, 16'h0002, 16'h0003, 16'h000a,
                         16'h0010, 16'h001f, 16'h008b, 16'h2061};

  always #5 clk_sys = ~clk_sys;

  npd_detector dut (.clk_sys(clk_sys), .reset(reset),
    .powerDownInN(powerDownInN), .wordData(wordData),
    .wordValid(wordValid), .frameTick(frameTick), .regAddr(regAddr),
    .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
    .regRdData_r(regRdData_r), .nonPcmDetect_r(nonPcmDetect_r),
    .cdStreamDetectFlag_r(cdStreamDetectFlag_r),
    .eventOut_r(eventOut_r), .irq_r(irq_r));

  npd_rx_model rx (.clk_sys(clk_sys), .tickEn(tickEn),
    .wordData(wordData), .wordValid(wordValid), .frameTick(frameTick));

  // =====================================================
  // Checking and bus tasks
  task check(input string what, input logic [15:0] seen,
             input logic [15:0] exp);
    samplesChecked++;
    if (seen !== exp) begin
      nFail++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task regWr(input logic [2:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    regAddr <= a;
    regWrData <= d;
    regWrite <= 1'b1;
    @(posedge clk_sys);
    regWrite <= 1'b0;
  endtask : regWr

  task expectRd(input string what, input logic [2:0] a,
                input logic [15:0] exp);
    @(posedge clk_sys);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk_sys);
    regRead <= 1'b0;
    #1 check(what, regRdData_r, exp);
  endtask : expectRd

  task waitCyc(input int n);
    repeat (n) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask : waitCyc

  // Bounded wait for a detect flag to drop
  task waitLow(input logic cd);
    int k;
    for (k = 0; k < 60; k++) begin
      if (!(cd ? cdStreamDetectFlag_r : nonPcmDetect_r)) break;
      @(negedge clk_sys);
    end
  endtask : waitLow

  function automatic logic [15:0] decodeOf(input npd_word_t pc);
    logic [4:0] t;
    logic nul;
    logic pau;
    logic rsv;
    t = pc[4:0];
    nul = (t == 5'h00);
    pau = (t == 5'h03);
    rsv = (t == 5'h02) || (t == 5'h0a) || (t >= 5'h10);
    decodeOf = {5'h00, !(nul || pau || rsv), (|pc[6:5]) || (|pc[15:13]),
                pc[7], rsv, pau, nul, t};
  endfunction : decodeOf

  task results();
    $display("checks %0d mismatches %0d", samplesChecked, nFail);
    if (nFail == 0 && samplesChecked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : results

  // =====================================================
  // Hang guard, well above the expected run length
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 30000) begin
      nFail++;
      results();
    end
  end

  // =====================================================
  // Main sequence
  initial begin
    repeat (16) @(posedge clk_sys);
    reset <= 1'b0;
    tickEn <= 1'b1;
    repeat (4) @(posedge clk_sys);
    expectRd("info rst", `NPD_ADDR_INFO, 16'h0000);
    expectRd("len rst", `NPD_ADDR_LENGTH, 16'h0000);
    expectRd("ctrl rst", `NPD_ADDR_CTRL, 16'h0001);
    regWr(`NPD_ADDR_IRQ_EN, 16'h0001);
    rx.sendBurst(3, `NPD_SYNC_ONE, 16'h0001, 16'h0100, 1'b0);
    waitCyc(3);
    check("short sync", nonPcmDetect_r, 16'h0000);
    expectRd("no capture", `NPD_ADDR_INFO, 16'h0000);
    rx.sendBurst(4, `NPD_SYNC_ONE, 16'h0081, 16'h1234, 1'b0);
    waitCyc(3);
    check("np set", nonPcmDetect_r, 16'h0001);
    check("irq up", irq_r, 16'h0001);
    expectRd("info", `NPD_ADDR_INFO, 16'h0081);
    expectRd("len", `NPD_ADDR_LENGTH, 16'h1234);
    expectRd("decode", `NPD_ADDR_DECODE, decodeOf(16'h0081));
    expectRd("irq stat", `NPD_ADDR_IRQ_STAT, 16'h0011);
    regWr(`NPD_ADDR_IRQ_CLR, 16'h0011);
    waitCyc(1);
    check("irq down", irq_r, 16'h0000);
    expectRd("stat clr", `NPD_ADDR_IRQ_STAT, 16'h0000);
    regWr(`NPD_ADDR_FLAGS, 16'h0000);
    expectRd("flags ro", `NPD_ADDR_FLAGS, 16'h0005);
    expectRd("clr reads", `NPD_ADDR_IRQ_CLR, 16'h0000);
    // Second sync restarts the timeout before it runs out
    waitCyc(3000);
    rx.sendBurst(4, `NPD_SYNC_ONE_ALT, 16'h0005, 16'h0abc, 1'b0);
    waitCyc(4085);
    check("np retrig", nonPcmDetect_r, 16'h0001);
    waitLow(1'b0);
    check("np lost", nonPcmDetect_r, 16'h0000);
    check("ev hold", eventOut_r, 16'h0001);
    waitCyc(1000);
    check("ev held", eventOut_r, 16'h0001);
    waitCyc(40);
    check("ev end", eventOut_r, 16'h0000);
    expectRd("info new", `NPD_ADDR_INFO, 16'h0005);
    for (i = 0; i < 8; i++) begin
      rx.sendBurst(4, i[0] ? `NPD_SYNC_ONE_ALT : `NPD_SYNC_ONE, tbl[i],
                   16'h0010 + 16'(i), 1'b1);
      expectRd("type", `NPD_ADDR_DECODE, decodeOf(tbl[i]));
      expectRd("len tbl", `NPD_ADDR_LENGTH, 16'h0010 + 16'(i));
    end
    // Mask the non-PCM source, shortest hold for the CD source
    regWr(`NPD_ADDR_CTRL, 16'h0004);
    waitCyc(1030);
    check("np masked", nonPcmDetect_r, 16'h0001);
    check("ev masked", eventOut_r, 16'h0000);
    rx.sendCdSync();
    waitCyc(3);
    check("cd set", cdStreamDetectFlag_r, 16'h0001);
    check("ev cd", eventOut_r, 16'h0001);
    waitCyc(4080);
    check("cd kept", cdStreamDetectFlag_r, 16'h0001);
    waitLow(1'b1);
    check("cd lost", cdStreamDetectFlag_r, 16'h0000);
    waitCyc(490);
    check("ev 512", eventOut_r, 16'h0001);
    waitCyc(40);
    check("ev off", eventOut_r, 16'h0000);
    waitCyc(200);
    check("cd stays", cdStreamDetectFlag_r, 16'h0000);
    @(posedge clk_sys);
    powerDownInN <= 1'b0;
    repeat (4) @(posedge clk_sys);
    powerDownInN <= 1'b1;
    repeat (4) @(posedge clk_sys);
    expectRd("info pd", `NPD_ADDR_INFO, 16'h0000);
    expectRd("len pd", `NPD_ADDR_LENGTH, 16'h0000);
    expectRd("ctrl pd", `NPD_ADDR_CTRL, 16'h0001);
    results();
  end

endmodule : tb_nonpcm_burst_detector
